//--- src/uam_top.v
// Two-channel asynchronous serial unit (UART mode) with an AXI4-Lite register slave.
// Assumes one clock aclk, synchronous active-low reset, pins sampled through two flops.
`timescale 1ns/1ps
`include "uam_map.vh"

// ----------------------------------------------------------------
// One serial channel: bit-rate divider, transmitter, receiver
// ----------------------------------------------------------------
module uam_channel #(
	parameter HAS_EXT = 0
) (
	// Clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	// Configuration from the register file
	input  wire       async_on,
	input  wire [7:0] mode_cfg,
	input  wire [7:0] ctl0,
	input  wire [7:0] brg,
	input  wire       tx_en,
	input  wire       rx_en,
	input  wire       irq_src,
	// Prescaler ticks and external clock edge
	input  wire       tick_f8,
	input  wire       tick_f32,
	input  wire       ext_tick,
	// Buffer access strobes
	input  wire       load,
	input  wire [8:0] load_data,
	input  wire       rb_read,
	// Synchronised serial input
	input  wire       rx_line,
	// Status and line outputs
	output reg        tx_bit,
	output reg        tx_idle,
	output reg        tbe,
	output reg        ri,
	output reg  [8:0] rx_data,
	output reg        overrun_flag,
	output reg        framing_error_flag,
	output reg        parity_error_flag,
	output reg        tx_irq,
	output reg        rx_irq
);
	localparam RX_IDLE  = 2'd0;
	localparam RX_START = 2'd1;
	localparam RX_BITS  = 2'd2;

	// Character length from the mode field
	function [3:0] char_len;
		input [2:0] m;
		begin
			case (m)
				`UAM_MODE_7: char_len = `UAM_LEN_7;
				`UAM_MODE_9: char_len = `UAM_LEN_9;
				default:     char_len = `UAM_LEN_8;
			endcase
		end
	endfunction

	// Bit reversal for MSB-first 8-bit characters
	function [7:0] rev8;
		input [7:0] d;
		integer k;
		begin
			rev8 = 8'h00;
			for (k = 0; k < 8; k = k + 1) begin
				rev8[k] = d[7 - k];
			end
		end
	endfunction

	reg  [7:0]  div_cnt;
	reg         os_tick;
	reg  [8:0]  tb_data;
	reg  [11:0] tx_sh;
	reg  [3:0]  tx_left;
	reg  [3:0]  tx_sub;
	reg  [1:0]  rx_state;
	reg  [3:0]  rx_sub;
	reg  [3:0]  rx_cnt;
	reg  [11:0] rx_sh;
	reg         rx_prev;

	// Frame shape shared by both directions
	wire [1:0]  cs       = ctl0[`C0_CLK_HI:`C0_CLK_LO];
	wire        int_tick = (cs == `UAM_CS_F1) ? 1'b1 : (cs == `UAM_CS_F8) ? tick_f8 : tick_f32;
	wire        src_tick = (HAS_EXT != 0 && mode_cfg[`MR_CKS]) ? ext_tick : int_tick;
	wire [3:0]  len      = char_len(mode_cfg[`MR_MODE_HI:`MR_MODE_LO]);
	wire        pe       = mode_cfg[`MR_PARITY_ENABLE_BIT];
	wire        odd      = ~mode_cfg[`MR_PRY];
	wire        two      = mode_cfg[`MR_STP];
	wire        msb      = ctl0[`C0_BIT_ORDER_SELECT] && (len == `UAM_LEN_8);
	wire [3:0]  total    = len + {3'b000, pe} + {3'b000, two} + `UAM_STOP_MIN;
	wire [8:0]  mask     = 9'h1ff >> (`UAM_LEN_9 - len);

	// Transmit frame: start bit low, data, optional parity, ones above for stop bits
	wire [8:0]  td     = tb_data & mask;
	wire [8:0]  tord   = msb ? {1'b0, rev8(td[7:0])} : td;
	wire        tpar   = ^td ^ odd;
	wire [12:0] tframe = (13'h1fff << (len + {3'b000, pe} + `UAM_STOP_MIN))
	                   | ({12'h000, tpar & pe} << (len + `UAM_STOP_MIN))
	                   | {3'b000, tord, 1'b0};
	wire        tx_go  = async_on && tx_en && !tbe && tx_idle;

	// Receive decode of the frame collected so far
	wire [11:0] nxt_sh = {rx_line, rx_sh[11:1]};
	wire [11:0] fbits  = nxt_sh >> (`UAM_RX_W - total);
	wire [8:0]  rraw   = fbits[8:0] & mask;
	wire [8:0]  rdat   = msb ? {1'b0, rev8(rraw[7:0])} : rraw;
	wire [3:0]  sp1    = len + {3'b000, pe};
	wire [3:0]  sp2    = sp1 + `UAM_STOP_MIN;
	wire        ferr   = ~fbits[sp1] | (two & ~fbits[sp2]);
	wire        perr   = pe & (^rraw ^ fbits[len] ^ odd);
	wire        finish = (rx_state == RX_BITS) && os_tick && (rx_sub == `UAM_SUB_LAST)
	                   && (rx_cnt == total - `UAM_STOP_MIN);
	// A read in the finishing cycle frees the buffer, so no overrun then
	wire        ovr    = ri && !rb_read;

	// Divider: one oversample tick per (n+1) source ticks, sixteen per bit
	always @(posedge aclk) begin
		if (!aresetn || !async_on) begin
			div_cnt <= `UAM_RST8;
			os_tick <= 1'b0;
		end else begin
			os_tick <= 1'b0;
			if (src_tick) begin
				if (div_cnt == `UAM_RST8) begin
					div_cnt <= brg;
					os_tick <= 1'b1;
				end else begin
					div_cnt <= div_cnt - 8'h01;
				end
			end
		end
	end

	// Transmitter; a frame in flight finishes even if tx_en drops, but is cut off when async_on drops
	always @(posedge aclk) begin
		if (!aresetn) begin
			tb_data <= 9'h000;
			tbe     <= 1'b1;
			tx_idle <= 1'b1;
			tx_bit  <= 1'b1;
			tx_sh   <= 12'h000;
			tx_left <= 4'h0;
			tx_sub  <= 4'h0;
			tx_irq  <= 1'b0;
		end else begin
			tx_irq <= 1'b0;
			if (load) begin
				tb_data <= load_data;
				tbe     <= 1'b0;
			end
			if (!async_on) begin
				tx_idle <= 1'b1;
				tx_bit  <= 1'b1;
			end else if (tx_go) begin
				tbe     <= 1'b1;
				tx_idle <= 1'b0;
				tx_bit  <= tframe[0];
				tx_sh   <= tframe[12:1];
				tx_left <= total;
				tx_sub  <= 4'h0;
				tx_irq  <= !irq_src;
			end else if (!tx_idle && os_tick) begin
				tx_sub <= tx_sub + 4'h1;
				if (tx_sub == `UAM_SUB_LAST) begin
					if (tx_left == 4'h0) begin
						tx_idle <= 1'b1;
						tx_bit  <= 1'b1;
						tx_irq  <= irq_src;
					end else begin
						tx_bit  <= tx_sh[0];
						tx_sh   <= {1'b1, tx_sh[11:1]};
						tx_left <= tx_left - 4'h1;
					end
				end
			end
		end
	end

	// Receiver; start edge, mid-bit confirm, then one sample every sixteen ticks
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_state <= RX_IDLE;
			rx_sub   <= 4'h0;
			rx_cnt   <= 4'h0;
			rx_sh    <= 12'h000;
			rx_prev  <= 1'b1;
			rx_data  <= 9'h000;
			ri       <= 1'b0;
			overrun_flag      <= 1'b0;
			framing_error_flag      <= 1'b0;
			parity_error_flag      <= 1'b0;
			rx_irq   <= 1'b0;
		end else begin
			rx_prev <= rx_line;
			rx_irq  <= 1'b0;
			// Read of the receive buffer clears ri and the framing and parity flags, not overrun; a new frame below wins
			if (rb_read) begin
				ri  <= 1'b0;
				framing_error_flag <= 1'b0;
				parity_error_flag <= 1'b0;
			end
			if (!rx_en) begin
				overrun_flag <= 1'b0;
			end
			if (!async_on || !rx_en) begin
				rx_state <= RX_IDLE;
			end else begin
				case (rx_state)
					RX_IDLE: begin
						if (rx_prev && !rx_line) begin
							rx_state <= RX_START;
							rx_sub   <= 4'h0;
						end
					end
					RX_START: begin
						if (os_tick) begin
							rx_sub <= rx_sub + 4'h1;
							if (rx_sub == `UAM_SUB_MID) begin
								rx_state <= rx_line ? RX_IDLE : RX_BITS;
								rx_sub   <= 4'h0;
								rx_cnt   <= 4'h0;
							end
						end
					end
					RX_BITS: begin
						if (os_tick) begin
							rx_sub <= rx_sub + 4'h1;
							if (rx_sub == `UAM_SUB_LAST) begin
								rx_sh  <= nxt_sh;
								rx_cnt <= rx_cnt + 4'h1;
							end
						end
						if (finish) begin
							rx_state <= RX_IDLE;
							if (ovr) begin
								overrun_flag <= 1'b1;
							end else begin
								rx_data <= rdat;
								ri      <= 1'b1;
								rx_irq  <= 1'b1;
								framing_error_flag     <= ferr;
								parity_error_flag     <= perr;
							end
						end
					end
					default: rx_state <= RX_IDLE;
				endcase
			end
		end
	end
endmodule

// ----------------------------------------------------------------
// Top: AXI4-Lite slave, register file, pin routing, two channels
// ----------------------------------------------------------------
module uam_top (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write channels
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read channels
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Serial pins
	input  wire        ch0_serial_in_pin,
	input  wire        ch1_serial_in_pin,
	input  wire        ch0_clk_pin,
	input  wire        port1_bit7_pin,
	output reg         ch0_serial_out_pin,
	output reg         ch0_serial_out_oe_n,
	output reg         ch1_serial_out_pin,
	output reg         ch1_serial_out_oe_n,
	// Pin mode and routed timer input
	output reg         ch0_clk_pin_is_input,
	output reg         timer_ext_input,
	// Interrupt request pulses
	output wire        ch0_tx_irq,
	output wire        ch0_rx_irq,
	output wire        ch1_tx_irq,
	output wire        ch1_rx_irq
);
	// Mode field selects one of the three UART character lengths
	function mode_ok;
		input [7:0] mr;
		begin
			mode_ok = (mr[`MR_MODE_HI:`MR_MODE_LO] == `UAM_MODE_7)
			       || (mr[`MR_MODE_HI:`MR_MODE_LO] == `UAM_MODE_8)
			       || (mr[`MR_MODE_HI:`MR_MODE_LO] == `UAM_MODE_9);
		end
	endfunction

	// Register index is mapped
	function mapped;
		input [9:0] idx;
		begin
			case (idx)
				`UAM_IDX_MR0, `UAM_IDX_BRG0, `UAM_IDX_TB0, `UAM_IDX_C00, `UAM_IDX_C10,
				`UAM_IDX_RB0, `UAM_IDX_MR1, `UAM_IDX_BRG1, `UAM_IDX_TB1, `UAM_IDX_C01,
				`UAM_IDX_C11, `UAM_IDX_RB1, `UAM_IDX_SERIAL_COMMON_CONTROL: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	endfunction

	// Pin drive {level, oe_n}; open drain only ever pulls low
	function [1:0] pin_drive;
		input on;
		input od;
		input bit_v;
		begin
			if (!on) begin
				pin_drive = 2'b11;
			end else if (od) begin
				pin_drive = {1'b0, bit_v};
			end else begin
				pin_drive = {bit_v, 1'b0};
			end
		end
	endfunction

	reg  [7:0]  mr0, mr1, brg0, brg1, c00, c01, serial_common_control;
	reg         te0, te1, re0, re1;
	reg         tb_hi0, tb_hi1;
	reg  [9:0]  aw_idx;
	reg         aw_full, w_full;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	reg  [4:0]  pre;
	reg  [3:0]  sync1, sync2;
	reg         clk_last;
	reg  [31:0] next_rdata;

	wire        tx_bit0, tx_bit1, idle0, idle1, tbe0, tbe1, ri0, ri1;
	wire        oer0, oer1, fer0, fer1, per0, per1;
	wire [8:0]  rd0, rd1;
	wire        async0   = mode_ok(mr0);
	wire        async1   = mode_ok(mr1);
	wire        wr_fire  = aw_full && w_full && !s_axi_bvalid;
	wire        wr_lo    = wr_fire && w_strb[0];
	wire        wr_hi    = wr_fire && w_strb[1];
	wire        rd_fire  = s_axi_arvalid && s_axi_arready;
	wire [9:0]  ar_idx   = s_axi_araddr[11:2];
	wire [1:0]  sel1     = {serial_common_control[`UC_SEL_HI], serial_common_control[`UC_SEL_LO]};
	wire        rx1_line = sel1[0] ? sync2[1] : 1'b1;
	wire        ext_tick = sync2[2] && !clk_last;
	wire [1:0]  drv0     = pin_drive(async0, c00[`C0_NCH], tx_bit0);
	wire [1:0]  drv1     = pin_drive(async1 && (sel1 == `UAM_SEL_BOTH), c01[`C0_NCH], tx_bit1);
	// Prescaler enables; compared at the constant's full width
	wire        f8_tick  = ({2'b00, pre[2:0]} == `UAM_PRE_F8);
	wire        f32_tick = (pre == `UAM_PRE_F32);

	// Two-flop synchronisers: rx0, rx1, external clock, port 1 bit 7
	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1    <= 4'hf;
			sync2    <= 4'hf;
			clk_last <= 1'b1;
		end else begin
			sync1    <= {port1_bit7_pin, ch0_clk_pin, ch1_serial_in_pin, ch0_serial_in_pin};
			sync2    <= sync1;
			clk_last <= sync2[2];
		end
	end

	// Free-running prescaler; f8 and f32 are single-cycle enables, not clocks
	always @(posedge aclk) begin
		if (!aresetn) begin
			pre <= 5'h00;
		end else begin
			pre <= pre + 5'h01;
		end
	end

	// Registered pins and routing
	always @(posedge aclk) begin
		if (!aresetn) begin
			ch0_serial_out_pin   <= 1'b1;
			ch0_serial_out_oe_n  <= 1'b1;
			ch1_serial_out_pin   <= 1'b1;
			ch1_serial_out_oe_n  <= 1'b1;
			ch0_clk_pin_is_input <= 1'b0;
			timer_ext_input      <= 1'b1;
		end else begin
			ch0_serial_out_pin   <= drv0[1];
			ch0_serial_out_oe_n  <= drv0[0];
			ch1_serial_out_pin   <= drv1[1];
			ch1_serial_out_oe_n  <= drv1[0];
			ch0_clk_pin_is_input <= mr0[`MR_CKS];
			timer_ext_input      <= serial_common_control[`UC_CNTR] ? sync2[0] : sync2[3];
		end
	end

	// Write path: address and data taken in either order, response after both
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `UAM_RESP_OK;
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			aw_idx  <= 10'h000;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_idx        <= s_axi_awaddr[11:2];
				aw_full       <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_full       <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_full      <= 1'b0;
				w_full       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(aw_idx) ? `UAM_RESP_OK : `UAM_RESP_ERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Register file; byte lane 0 holds all 8-bit registers, lane 1 the ninth data bit
	always @(posedge aclk) begin
		if (!aresetn) begin
			mr0  <= `UAM_RST8;
			mr1  <= `UAM_RST8;
			brg0 <= `UAM_RST8;
			brg1 <= `UAM_RST8;
			c00  <= `UAM_RST8;
			c01  <= `UAM_RST8;
			serial_common_control <= `UAM_RST8;
			te0  <= 1'b0;
			te1  <= 1'b0;
			re0  <= 1'b0;
			re1  <= 1'b0;
			tb_hi0 <= 1'b0;
			tb_hi1 <= 1'b0;
		end else begin
			if (wr_hi && aw_idx == `UAM_IDX_TB0) tb_hi0 <= w_data[8];
			if (wr_hi && aw_idx == `UAM_IDX_TB1) tb_hi1 <= w_data[8];
			if (wr_lo) begin
				case (aw_idx)
					`UAM_IDX_MR0:  mr0  <= w_data[7:0];
					`UAM_IDX_MR1:  mr1  <= w_data[7:0];
					`UAM_IDX_BRG0: brg0 <= w_data[7:0];
					`UAM_IDX_BRG1: brg1 <= w_data[7:0];
					`UAM_IDX_C00:  c00  <= w_data[7:0] & `C0_WMASK;
					`UAM_IDX_C01:  c01  <= w_data[7:0] & `C0_WMASK;
					`UAM_IDX_SERIAL_COMMON_CONTROL: serial_common_control <= w_data[7:0];
					`UAM_IDX_C10: begin
						te0 <= w_data[`C1_TE];
						re0 <= w_data[`C1_RE];
					end
					`UAM_IDX_C11: begin
						te1 <= w_data[`C1_TE];
						re1 <= w_data[`C1_RE];
					end
					default: ;
				endcase
			end
		end
	end

	// Read mux; write-only registers read as zero
	always @* begin
		next_rdata = 32'h0000_0000;
		case (ar_idx)
			`UAM_IDX_MR0:  next_rdata[7:0] = mr0;
			`UAM_IDX_MR1:  next_rdata[7:0] = mr1;
			`UAM_IDX_C00:  next_rdata[7:0] = c00 | {4'h0, idle0, 3'b000};
			`UAM_IDX_C01:  next_rdata[7:0] = c01 | {4'h0, idle1, 3'b000};
			`UAM_IDX_C10:  next_rdata[7:0] = {4'h0, ri0, re0, tbe0, te0};
			`UAM_IDX_C11:  next_rdata[7:0] = {4'h0, ri1, re1, tbe1, te1};
			`UAM_IDX_SERIAL_COMMON_CONTROL: next_rdata[7:0] = serial_common_control;
			`UAM_IDX_RB0:  next_rdata[15:0] = {oer0 | fer0 | per0, per0, fer0, oer0, 3'b000, rd0};
			`UAM_IDX_RB1:  next_rdata[15:0] = {oer1 | fer1 | per1, per1, fer1, oer1, 3'b000, rd1};
			default:       next_rdata = 32'h0000_0000;
		endcase
	end

	// Read path: answer one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `UAM_RESP_OK;
		end else begin
			if (rd_fire) begin
				s_axi_rdata   <= next_rdata;
				s_axi_rresp   <= mapped(ar_idx) ? `UAM_RESP_OK : `UAM_RESP_ERR;
				s_axi_rvalid  <= 1'b1;
				s_axi_arready <= 1'b0;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Channel 0 has the external clock option, channel 1 does not
	uam_channel #(.HAS_EXT(1)) u_ch0 (
		.aclk(aclk), .aresetn(aresetn), .async_on(async0), .mode_cfg(mr0), .ctl0(c00),
		.brg(brg0), .tx_en(te0), .rx_en(re0), .irq_src(serial_common_control[`UC_IRS0]),
		.tick_f8(f8_tick), .tick_f32(f32_tick), .ext_tick(ext_tick),
		.load(wr_lo && aw_idx == `UAM_IDX_TB0), .load_data({wr_hi ? w_data[8] : tb_hi0, w_data[7:0]}),
		.rb_read(rd_fire && ar_idx == `UAM_IDX_RB0), .rx_line(sync2[0]),
		.tx_bit(tx_bit0), .tx_idle(idle0), .tbe(tbe0), .ri(ri0), .rx_data(rd0),
		.overrun_flag(oer0), .framing_error_flag(fer0), .parity_error_flag(per0), .tx_irq(ch0_tx_irq), .rx_irq(ch0_rx_irq)
	);

	uam_channel #(.HAS_EXT(0)) u_ch1 (
		.aclk(aclk), .aresetn(aresetn), .async_on(async1), .mode_cfg(mr1), .ctl0(c01),
		.brg(brg1), .tx_en(te1), .rx_en(re1), .irq_src(serial_common_control[`UC_IRS1]),
		.tick_f8(f8_tick), .tick_f32(f32_tick), .ext_tick(1'b0),
		.load(wr_lo && aw_idx == `UAM_IDX_TB1), .load_data({wr_hi ? w_data[8] : tb_hi1, w_data[7:0]}),
		.rb_read(rd_fire && ar_idx == `UAM_IDX_RB1), .rx_line(rx1_line),
		.tx_bit(tx_bit1), .tx_idle(idle1), .tbe(tbe1), .ri(ri1), .rx_data(rd1),
		.overrun_flag(oer1), .framing_error_flag(fer1), .parity_error_flag(per1), .tx_irq(ch1_tx_irq), .rx_irq(ch1_rx_irq)
	);
endmodule

//--- pkg/uam_map.vh
// Register indices, field positions, codes and counts for the UART-mode serial unit.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef UAM_MAP_VH
`define UAM_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define UAM_IDX_MR0      10'h0a0
`define UAM_IDX_BRG0     10'h0a1
`define UAM_IDX_TB0      10'h0a2
`define UAM_IDX_C00      10'h0a4
`define UAM_IDX_C10      10'h0a5
`define UAM_IDX_RB0      10'h0a6
`define UAM_IDX_MR1      10'h0a8
`define UAM_IDX_BRG1     10'h0a9
`define UAM_IDX_TB1      10'h0aa
`define UAM_IDX_C01      10'h0ac
`define UAM_IDX_C11      10'h0ad
`define UAM_IDX_RB1      10'h0ae
`define UAM_IDX_SERIAL_COMMON_CONTROL     10'h0b0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MR_MODE_HI       2
`define MR_MODE_LO       0
`define MR_CKS           3
`define MR_STP           4
`define MR_PRY           5
`define MR_PARITY_ENABLE_BIT          6
`define C0_CLK_HI        1
`define C0_CLK_LO        0
`define C0_SHIFT_REGISTER_EMPTY_FLAG         3
`define C0_WMASK         8'he3
`define C1_TE            0
`define C1_TI            1
`define C1_RE            2
`define C1_RI            3
`define UC_IRS0          0
`define UC_IRS1          1
`define UC_RRM           2
`define UC_SEL_LO        4
`define UC_SEL_HI        5
`define UC_CNTR          6
`define C0_BIT_ORDER_SELECT         7
`define C0_NCH           5

// ----------------------------------------------------------------
// Codes, reset values and counts
// ----------------------------------------------------------------
`define UAM_MODE_7       3'b100
`define UAM_MODE_8       3'b101
`define UAM_MODE_9       3'b110
`define UAM_LEN_7        4'd7
`define UAM_LEN_8        4'd8
`define UAM_LEN_9        4'd9
`define UAM_CS_F1        2'b00
`define UAM_CS_F8        2'b01
`define UAM_SEL_BOTH     2'b11
`define UAM_PRE_F8       5'h07
`define UAM_PRE_F32      5'h1f
`define UAM_SUB_MID      4'd7
`define UAM_SUB_LAST     4'd15
`define UAM_RX_W         4'd12
`define UAM_STOP_MIN     4'd1
`define UAM_RST8         8'h00
`define UAM_RESP_OK      2'b00
`define UAM_RESP_ERR     2'b10

`endif

//--- dv/uam_checker_assertions.sv
// Port checker for the serial unit: bus answers, idle pin, pulse widths.
// Assumes binding onto uam_top; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module uam_checker (
	// Clock and reset
	input wire        aclk,
	input wire        aresetn,
	// Bus handshakes
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// Serial side
	input wire        ch0_serial_out_pin,
	input wire        ch0_serial_out_oe_n,
	input wire        ch0_tx_irq,
	input wire        ch0_rx_irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Write answer shows two edges after the take, read answer one edge after
	chk_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	chk_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	// A pending answer must not move, or software reads a torn value
	chk_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	chk_write_busy: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	chk_b_release: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write answer stuck");
	// Line released high straight out of reset
	chk_idle_high: assert property (
		$rose(aresetn) |-> ch0_serial_out_pin && ch0_serial_out_oe_n)
		else $error("line not idle");
	chk_tx_pulse: assert property (
		ch0_tx_irq |=> !ch0_tx_irq)
		else $error("tx request too long");
	chk_rx_pulse: assert property (
		ch0_rx_irq |=> !ch0_rx_irq)
		else $error("rx request too long");
endmodule
bind uam_top uam_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .ch0_serial_out_pin,
	.ch0_serial_out_oe_n, .ch0_tx_irq, .ch0_rx_irq);

//--- dv/uam_remote.sv
// Remote transceiver: echoes what it hears after a chosen delay.
// Assumes a pulled-up line; it can also hold the line low as a fault.
`timescale 1ns/1ps
module uam_remote (
	// Clock and line
	input  wire       aclk,
	input  wire       line_in,
	// Delay and fault control
	input  wire [2:0] dly,
	input  wire       hold_low,
	output wire       line_out
);
	reg [7:0] sh = 8'hff;
	// Delay line, so a slow peer answers several cycles late
	always @(posedge aclk) begin
		sh <= {sh[6:0], line_in};
	end
	// Held low, the peer never sends stop bits
	assign line_out = hold_low ? 1'h0 : sh[dly];
endmodule

//--- dv/testbench.sv
// Self-checking bench: register bus, looped-back frames, pin routing.
// Assumes uam_top, the remote model and the map header on the path.
`timescale 1ns/1ps
`include "uam_map.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
$display("CHECK FAILED %0t got %0h exp %0h", $time, (a), (e)); end end
module testbench;
	localparam [33:0] RBM = 34'h3_0000_f1ff;
	reg         aclk = 1'h0, aresetn = 1'h0, p17 = 1'h0, hold = 1'h0;
	reg  [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	reg  [31:0] s_axi_wdata = 32'h0000_0000;
	reg  [3:0]  s_axi_wstrb = 4'h0;
	reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	reg  [2:0]  dly = 3'h0;
	reg  [8:0]  d, m;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire        tx0, oe0, tx1, oe1, rx0, ckin, tmr, ch0_tx_irq, ch0_rx_irq;
	wire        ln0 = oe0 ? 1'h1 : tx0;
	reg  [33:0] eq[$], mq[$];
	int         wq[$];
	int         fail_count = 0, samples_checked = 0, cyc = 0, lc = 0, runs = 0, txe = 0, n, k;
	int         wexp;
	always #2 aclk = ~aclk;
	uam_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ch0_serial_in_pin(rx0),
		.ch1_serial_in_pin(1'h1), .ch0_clk_pin(1'h0), .port1_bit7_pin(p17),
		.ch0_serial_out_pin(tx0), .ch0_serial_out_oe_n(oe0), .ch1_serial_out_pin(tx1),
		.ch1_serial_out_oe_n(oe1), .ch0_clk_pin_is_input(ckin), .timer_ext_input(tmr),
		.ch0_tx_irq, .ch0_rx_irq, .ch1_tx_irq(), .ch1_rx_irq());
	uam_remote peer (.aclk, .line_in(ln0), .dly, .hold_low(hold), .line_out(rx0));
	// Oldest note against each read; second low run of a frame is one bit
	always @(negedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			`CHK({s_axi_rresp, s_axi_rdata} & mq[0], eq[0]);
			void'(eq.pop_front());
			void'(mq.pop_front());
		end
		if (ch0_tx_irq === 1'h1) txe++;
		if (ln0 === 1'h0) lc++;
		else if (lc > 0) begin
			runs++;
			if (runs == 2 && wq.size() > 0) begin
				wexp = wq.pop_front();
				`CHK(lc, wexp);
			end
			lc = 0;
		end
	end
	task automatic wr(input [9:0] i, input [31:0] v, input [3:0] s);
		reg ra, rw, rb;
		begin
			@(posedge aclk);
			s_axi_awaddr <= {i, 2'h0};
			s_axi_wdata <= v;
			s_axi_wstrb <= s;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
			rb = 1'h0;
			while (!rb) begin
				@(negedge aclk);
				ra = s_axi_awready;
				rw = s_axi_wready;
				rb = s_axi_bvalid;
				@(posedge aclk);
				if (ra) s_axi_awvalid <= 1'h0;
				if (rw) s_axi_wvalid <= 1'h0;
			end
			s_axi_bready <= 1'h0;
		end
	endtask
	task automatic rd(input [9:0] i, input [33:0] e, input [33:0] mk = 34'h3_ffff_ffff);
		reg ra, rv;
		begin
			eq.push_back(e & mk);
			mq.push_back(mk);
			@(posedge aclk);
			s_axi_araddr <= {i, 2'h0};
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
			rv = 1'h0;
			while (!rv) begin
				@(negedge aclk);
				ra = s_axi_arready;
				rv = s_axi_rvalid;
				@(posedge aclk);
				if (ra) s_axi_arvalid <= 1'h0;
			end
			s_axi_rready <= 1'h0;
		end
	endtask
	task automatic complete_run;
		begin
			$display("checks %0d failures %0d", samples_checked, fail_count);
			if (fail_count == 0 && samples_checked > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// Hang guard, well above the longest frame sequence
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		void'($urandom(45));
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		rd(`UAM_IDX_C10, 34'h0_0000_0002);
		rd(`UAM_IDX_C00, 34'h0_0000_0008);
		rd(10'h0a3, 34'h2_0000_0000);
		wr(`UAM_IDX_BRG0, 32'h0000_0055, 4'h1);
		rd(`UAM_IDX_BRG0, 34'h0_0000_0000);
		wr(`UAM_IDX_C10, 32'h0000_00ff, 4'h1);
		rd(`UAM_IDX_C10, 34'h0_0000_0007);
		wr(`UAM_IDX_SERIAL_COMMON_CONTROL, 32'h0000_0001, 4'h1);
		// Modes 7/8/9 looped back; f8 with two stops and MSB first, then open drain
		for (int i = 0; i < 3; i++) begin
			n = $urandom % 3;
			dly <= $urandom % 8;
			m = (i == 0) ? 9'h07f : (i == 1) ? 9'h0ff : 9'h1ff;
			d = ($urandom & m & ~9'h0e7) | (9'h0a5 & m);
			wr(`UAM_IDX_MR0, 32'h0000_0064 | i | ((i == 1) << 4), 4'h1);
			wr(`UAM_IDX_BRG0, n, 4'h1);
			wr(`UAM_IDX_C00, (i == 1) ? 32'h0000_0081 : (i == 2) ? 32'h0000_0020 : 0, 4'h1);
			wq.push_back(16 * (n + 1) * ((i == 1) ? 8 : 1));
			runs = 0;
			k = txe;
			if (i == 2) wr(`UAM_IDX_TB0, {23'h0, d[8], 8'h00}, 4'h2);
			wr(`UAM_IDX_TB0, {23'h0, d}, 4'h1);
			do @(negedge aclk); while (ch0_rx_irq !== 1'h1);
			rd(`UAM_IDX_RB0, {25'h0, d}, RBM);
			rd(`UAM_IDX_C10, 34'h0_0000_0007);
			while (txe == k) @(posedge aclk);
		end
		// Peer holds the line low: missing stop bit
		wr(`UAM_IDX_MR0, 32'h0000_0005, 4'h1);
		hold <= 1'h1;
		do @(negedge aclk); while (ch0_rx_irq !== 1'h1);
		hold <= 1'h0;
		`CHK({tx0, oe0}, 2'h1);
		rd(`UAM_IDX_RB0, 34'h0_0000_a000, RBM);
		wr(`UAM_IDX_MR0, 32'h0000_000d, 4'h1);
		wr(`UAM_IDX_MR1, 32'h0000_0005, 4'h1);
		wr(`UAM_IDX_SERIAL_COMMON_CONTROL, 32'h0000_0070, 4'h1);
		repeat (4) @(posedge aclk);
		`CHK({ckin, oe1, tx1, tmr}, 4'hb);
		wr(`UAM_IDX_SERIAL_COMMON_CONTROL, 32'h0000_0010, 4'h1);
		repeat (4) @(posedge aclk);
		`CHK({oe1, tmr}, 2'h2);
		`CHK(wq.size(), 0);
		complete_run();
	end
endmodule
